// ---- logic/pmg_power_ctrl.sv ----
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "pmg_defines.svh"
module pmg_power_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pmg_pkg::pmg_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pmg_pkg::pmg_cpu_evt_t cpu_evt_i,
  input wire logic retention_config_bit_i,
  input wire logic vreg_ready_i,
  output logic cpu_halt_o,
  output logic idle_o,
  output logic sleep_o,
  output logic [`PMG_NUM_PERIPH-1:0] periph_clk_en_o,
  output logic [`PMG_NUM_PERIPH-1:0] periph_access_en_o,
  output logic regulator_standby_o,
  output logic retention_reg_en_o,
  output logic core_logic_power_o,
  output logic retained_power_o
);
  import pmg_pkg::*;

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [1:0] {
    PMG_RUN,
    PMG_IDLE,
    PMG_SLEEP,
    PMG_REG_WAKE
  } pmg_state_t;

  typedef enum logic [1:0] {
    PMG_KEY_LOCKED,
    PMG_KEY_HALF,
    PMG_KEY_OPEN
  } pmg_key_t;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] pmg_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Reset image of each disable register; its zero bits are the storage bits
  function automatic logic [31:0] pmg_dis_rst(input logic [2:0] idx);
    logic [31:0] res;
    res = 32'hFFFFFFFF;
    case (idx)
      3'h1: res = `PMG_RST_DIS1;
      3'h2: res = `PMG_RST_DIS2;
      3'h3: res = `PMG_RST_DIS3;
      3'h4: res = `PMG_RST_DIS4;
      3'h5: res = `PMG_RST_DIS5;
      3'h6: res = `PMG_RST_DIS6;
      3'h7: res = `PMG_RST_DIS7;
      default: res = 32'hFFFFFFFF;
    endcase
    return res;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  pmg_state_t state;
  pmg_state_t next_state;
  pmg_key_t key_state;
  pmg_key_t next_key_state;
  logic [31:0] dis_reg [1:7];
  logic dis_lock;
  logic sleep_enable_bit;
  logic regulator_standby_bit;
  logic retention_enable_bit;
  logic [`PMG_NUM_PERIPH-1:0] stop_in_idle_bit;
  logic retention_config_bit;
  logic cfg_loaded;
  logic standby_used;
  logic vreg_meta;
  logic vreg_sync;
  logic ack;
  logic [31:0] rdata;
  pmg_reg_mode_t reg_mode;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire req = wb_i.cyc & wb_i.stb;
  wire commit = req & ack;
  wire wr = commit & wb_i.we;
  wire hit_dis_ctrl = wb_i.adr == `PMG_OFS_DIS_CTRL;
  wire hit_pwr = wb_i.adr == `PMG_OFS_PWR_CTRL;
  wire hit_osc = wb_i.adr == `PMG_OFS_OSC_CTRL;
  wire hit_key = wb_i.adr == `PMG_OFS_SYS_KEY;
  wire hit_stop_in_idle_bit = wb_i.adr == `PMG_OFS_STOP_IDLE;
  wire hit_stat = wb_i.adr == `PMG_OFS_STATUS;
  wire [7:0] dis_ofs = wb_i.adr - `PMG_OFS_DIS_BASE;
  wire [2:0] dis_idx = dis_ofs[6:4] + 3'h1;
  wire hit_dis = (wb_i.adr >= `PMG_OFS_DIS_BASE) && (dis_ofs[3:0] == 4'h0)
    && (dis_ofs[7:4] < 4'h7);
  wire unlocked = key_state == PMG_KEY_OPEN;
  wire [31:0] wr_merged_key = pmg_merge(32'h00000000, wb_i.dat, wb_i.sel);

  // ****************************************************************
  // Unlock sequence
  // ****************************************************************
  // Once open, only a write to the key register moves the key state, so a protected
  // write may follow the keys and stays unlocked until the next key write
  always_comb begin
    next_key_state = key_state;
    if (wr && hit_key) begin
      case (key_state)
        PMG_KEY_LOCKED: begin
          if (wr_merged_key == `PMG_KEY_FIRST) begin
            next_key_state = PMG_KEY_HALF;
          end
        end
        PMG_KEY_HALF: begin
          if (wr_merged_key == `PMG_KEY_SECOND) begin
            next_key_state = PMG_KEY_OPEN;
          end else begin
            next_key_state = PMG_KEY_LOCKED;
          end
        end
        default: next_key_state = PMG_KEY_LOCKED;
      endcase
    end else if (wr && key_state == PMG_KEY_HALF) begin
      // Keys must be back-to-back writes; any other write between them relocks, a read does not
      next_key_state = PMG_KEY_LOCKED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_state <= PMG_KEY_LOCKED;
    end else begin
      key_state <= next_key_state;
    end
  end

  // ****************************************************************
  // Wishbone slave: one wait state, ack for one cycle
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_dis_ctrl) begin
      rd_mux[`PMG_BIT_DIS_LOCK] = dis_lock;
    end else if (hit_dis) begin
      rd_mux = dis_reg[dis_idx] | pmg_dis_rst(dis_idx);
    end else if (hit_pwr) begin
      rd_mux[`PMG_BIT_REG_STANDBY] = regulator_standby_bit;
      rd_mux[`PMG_BIT_RET_EN] = retention_enable_bit;
    end else if (hit_osc) begin
      rd_mux[`PMG_BIT_SLEEP_EN] = sleep_enable_bit;
    end else if (hit_stop_in_idle_bit) begin
      rd_mux[`PMG_NUM_PERIPH-1:0] = stop_in_idle_bit;
    end else if (hit_stat) begin
      rd_mux[1:0] = state;
      rd_mux[3:2] = reg_mode;
      rd_mux[4] = unlocked;
      rd_mux[5] = retention_config_bit;
      rd_mux[6] = vreg_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata <= 32'h00000000;
    end else if (req && !ack && !wb_i.we) begin
      rdata <= rd_mux;
    end
  end

  assign wb_dat_o = rdata;
  assign wb_ack_o = ack;

  // ****************************************************************
  // Protected control bits
  // ****************************************************************
  wire [31:0] osc_new = pmg_merge({27'h0, sleep_enable_bit, 4'h0}, wb_i.dat, wb_i.sel);
  wire [31:0] ctl_new = pmg_merge({20'h0, dis_lock, 11'h0}, wb_i.dat, wb_i.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_enable_bit <= 1'b0;
      dis_lock <= 1'b0;
    end else begin
      if (wr && hit_osc && unlocked) begin
        sleep_enable_bit <= osc_new[`PMG_BIT_SLEEP_EN];
      end
      if (wr && hit_dis_ctrl && unlocked) begin
        dis_lock <= ctl_new[`PMG_BIT_DIS_LOCK];
      end
    end
  end

  // ****************************************************************
  // Module-disable registers
  // ****************************************************************
  // Locked writes still get their ack; only the store is suppressed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 1; i <= 7; i++) begin
        dis_reg[i] <= 32'h00000000;
      end
    end else if (wr && hit_dis && !dis_lock) begin
      dis_reg[dis_idx] <= pmg_merge(dis_reg[dis_idx], wb_i.dat, wb_i.sel)
        & ~pmg_dis_rst(dis_idx);
    end
  end

  // Gather the disable bits into one peripheral vector
  logic [`PMG_NUM_PERIPH-1:0] periph_dis;
  assign periph_dis[0] = dis_reg[1][0]; // ADC
  assign periph_dis[1] = dis_reg[1][12]; // Voltage reference
  assign periph_dis[2] = dis_reg[1][20]; // Voltage detector
  assign periph_dis[3] = dis_reg[2][0]; // Comparator 1
  assign periph_dis[4] = dis_reg[2][1]; // Comparator 2
  assign periph_dis[5] = dis_reg[2][24]; // Logic cell 1
  assign periph_dis[6] = dis_reg[2][25]; // Logic cell 2
  assign periph_dis[7] = dis_reg[3][8]; // Multi-output capture
  assign periph_dis[8] = dis_reg[3][9]; // Single capture 2
  assign periph_dis[9] = dis_reg[3][10]; // Single capture 3
  assign periph_dis[10] = dis_reg[4][0]; // Timer1
  assign periph_dis[11] = dis_reg[5][0]; // UART1
  assign periph_dis[12] = dis_reg[5][1]; // UART2
  assign periph_dis[13] = dis_reg[5][8]; // SPI1
  assign periph_dis[14] = dis_reg[5][9]; // SPI2
  assign periph_dis[15] = dis_reg[6][0]; // RTC
  assign periph_dis[16] = dis_reg[6][8]; // Reference clock out
  assign periph_dis[17] = dis_reg[7][3]; // CRC

  // ****************************************************************
  // Unprotected control: power control and stop-in-idle bits
  // ****************************************************************
  wire [31:0] pwr_new = pmg_merge({30'h0, retention_enable_bit, regulator_standby_bit},
    wb_i.dat, wb_i.sel);
  wire [31:0] stop_in_idle_bit_new = pmg_merge({14'h0, stop_in_idle_bit}, wb_i.dat, wb_i.sel);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regulator_standby_bit <= 1'(`PMG_RST_PWR_CTRL);
      retention_enable_bit <= 1'b0;
      stop_in_idle_bit <= '0;
    end else begin
      if (wr && hit_pwr) begin
        regulator_standby_bit <= pwr_new[`PMG_BIT_REG_STANDBY];
        retention_enable_bit <= pwr_new[`PMG_BIT_RET_EN];
      end
      if (wr && hit_stop_in_idle_bit) begin
        stop_in_idle_bit <= stop_in_idle_bit_new[`PMG_NUM_PERIPH-1:0];
      end
    end
  end

  // ****************************************************************
  // Configuration word capture and regulator ready synchroniser
  // ****************************************************************
  // The config bit is caught once after reset release, like a strap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_loaded <= 1'b0;
      retention_config_bit <= 1'b1;
    end else if (!cfg_loaded) begin
      cfg_loaded <= 1'b1;
      retention_config_bit <= retention_config_bit_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vreg_meta <= 1'b0;
      vreg_sync <= 1'b0;
    end else begin
      vreg_meta <= vreg_ready_i;
      vreg_sync <= vreg_meta;
    end
  end

  // ****************************************************************
  // Regulator mode decode
  // ****************************************************************
  wire use_standby = ~regulator_standby_bit;
  wire use_retention = retention_enable_bit & ~retention_config_bit;
  assign reg_mode = !use_retention ? (use_standby ? PMG_REG_STANDBY : PMG_REG_NORMAL)
    : (use_standby ? PMG_REG_STANDBY_RET : PMG_REG_RETENTION);

  // ****************************************************************
  // Power mode state machine
  // ****************************************************************
  wire irq_wake = cpu_evt_i.irq_valid && (cpu_evt_i.irq_prio > cpu_evt_i.cpu_prio);
  wire force_wake = cpu_evt_i.reset_req | cpu_evt_i.wdt_timeout;

  always_comb begin
    next_state = state;
    case (state)
      PMG_RUN: begin
        if (cpu_evt_i.wait_exec) begin
          next_state = sleep_enable_bit ? PMG_SLEEP : PMG_IDLE;
        end
      end
      PMG_IDLE: begin
        if (irq_wake || force_wake) begin
          next_state = PMG_RUN;
        end
      end
      PMG_SLEEP: begin
        if (irq_wake || force_wake) begin
          next_state = standby_used ? PMG_REG_WAKE : PMG_RUN;
        end else if (cpu_evt_i.irq_valid) begin
          // Low-priority interrupt restarts clocks but keeps the CPU halted
          next_state = PMG_IDLE;
        end
      end
      PMG_REG_WAKE: begin
        if (vreg_sync) begin
          next_state = PMG_RUN;
        end
      end
      default: next_state = PMG_RUN;
    endcase
  end

  // Standby choice is latched at Sleep entry so a later write cannot skip the wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PMG_RUN;
      standby_used <= 1'b0;
    end else begin
      state <= next_state;
      if (state == PMG_RUN && next_state == PMG_SLEEP) begin
        standby_used <= use_standby;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  wire in_idle = state == PMG_IDLE;
  wire in_sleep = state == PMG_SLEEP;
  // Timer1 and RTC run from their own low-power clock during Sleep
  wire [`PMG_NUM_PERIPH-1:0] sleep_keep = (`PMG_NUM_PERIPH'(1) << 10)
    | (`PMG_NUM_PERIPH'(1) << 15);
  wire [`PMG_NUM_PERIPH-1:0] idle_stop = in_idle ? stop_in_idle_bit : '0;
  wire [`PMG_NUM_PERIPH-1:0] sleep_stop = in_sleep ? ~sleep_keep : '0;

  assign cpu_halt_o = state != PMG_RUN;
  assign idle_o = in_idle;
  assign sleep_o = in_sleep;
  assign periph_clk_en_o = ~periph_dis & ~idle_stop & ~sleep_stop;
  assign periph_access_en_o = ~periph_dis;
  assign regulator_standby_o = in_sleep & use_standby;
  assign retention_reg_en_o = in_sleep & use_retention;
  assign core_logic_power_o = ~(in_sleep & use_retention);
  assign retained_power_o = 1'b1;
endmodule

// ---- logic/pmg_defines.svh ----
`ifndef PMG_DEFINES_SVH
`define PMG_DEFINES_SVH
// Overview of operation
// - Idle halts the CPU; clocks without a stop-in-idle bit set keep running for fast exit.
// - A peripheral with its stop-in-idle bit set is clock-halted during Idle.
// - Wait with sleep-enable bit 4 clear enters Idle.
// - Only an enabled interrupt above CPU priority wakes; otherwise stay halted.
// - Any device reset or watchdog time-out also ends Idle.
// - Sleep-enable bit changes only after the system unlock sequence.
// - Module-disable bit 1 stops that peripheral's clocks; 0 (default) enables.
// - Disabled peripheral ignores register writes; its reads are invalid.
// - With the lock set, module-disable writes complete but change nothing.
// - Lock is bit 11 of disable control; changing it needs the unlock sequence.
// - Disable bits: ADC, vref, detector; comparators and logic cells.
// - Disable bits: capture modules 8,9,10 in register 3; Timer1 bit 0 reg 4.
// - Disable bits: UART1/2 bits 0/1, SPI1/2 bits 8/9 in register 5.
// - Disable bits: RTC bit 0, refclk bit 8 reg 6; CRC bit 3 reg 7.
// - Standby bit 0 of power control clear puts regulator in standby in Sleep.
// - After a direct wake from Sleep with standby, execution waits until the regulator is ready.
// - Retention regulator on only in Sleep, config bit 0 and enable bit 1.
// - Retention keeps RAM, watchdog, Timer1 and RTC powered, rest off.
// - Regulator mode decoded from standby, retention enable, retention config.
// - Wait with sleep-enable set enters Sleep instead of Idle.
// - Two back-to-back key writes unlock; a later key write relocks.

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PMG_OFS_DIS_CTRL 8'h00
`define PMG_OFS_DIS_BASE 8'h10
`define PMG_OFS_PWR_CTRL 8'h80
`define PMG_OFS_OSC_CTRL 8'h84
`define PMG_OFS_SYS_KEY 8'h88
`define PMG_OFS_STOP_IDLE 8'h8C
`define PMG_OFS_STATUS 8'h90

// ****************************************************************
// Field positions
// ****************************************************************
`define PMG_BIT_SLEEP_EN 4
`define PMG_BIT_DIS_LOCK 11
`define PMG_BIT_REG_STANDBY 0
`define PMG_BIT_RET_EN 1

// ****************************************************************
// Keys and reset values
// ****************************************************************
`define PMG_KEY_FIRST 32'hAA996655
`define PMG_KEY_SECOND 32'h556699AA
`define PMG_RST_DIS1 32'hFFEFEFFE
`define PMG_RST_DIS2 32'hFCFFFFFC
`define PMG_RST_DIS3 32'hFFFFF8FF
`define PMG_RST_DIS4 32'hFFFFFFFE
`define PMG_RST_DIS5 32'hFFFCFCFC
`define PMG_RST_DIS6 32'hFFFFFEFE
`define PMG_RST_DIS7 32'hFFFFFFF7
`define PMG_RST_PWR_CTRL 32'h00000001
`define PMG_RST_OSC_CTRL 32'h00000000
`define PMG_NUM_PERIPH 18
`endif

// ---- logic/pmg_pkg.sv ----
package pmg_pkg;
  // Classic Wishbone request from the bus master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmg_wb_req_t;

  // Wake and entry events from the CPU and interrupt controller
  typedef struct packed {
    logic wait_exec;
    logic irq_valid;
    logic [2:0] irq_prio;
    logic [2:0] cpu_prio;
    logic wdt_timeout;
    logic reset_req;
  } pmg_cpu_evt_t;

  typedef enum logic [1:0] {
    PMG_REG_NORMAL,
    PMG_REG_STANDBY,
    PMG_REG_RETENTION,
    PMG_REG_STANDBY_RET
  } pmg_reg_mode_t;
endpackage

// ---- sim/pmg_checker.sv ----
`timescale 1ns/100ps
`include "pmg_defines.svh"
// ******
// Port checker for the power controller
// ******
module pmg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pmg_pkg::pmg_wb_req_t wb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire pmg_pkg::pmg_cpu_evt_t cpu_evt_i,
  input wire logic retention_config_bit_i,
  input wire logic vreg_ready_i,
  input wire logic cpu_halt_o,
  input wire logic idle_o,
  input wire logic sleep_o,
  input wire logic [`PMG_NUM_PERIPH-1:0] periph_clk_en_o,
  input wire logic [`PMG_NUM_PERIPH-1:0] periph_access_en_o,
  input wire logic regulator_standby_o,
  input wire logic retention_reg_en_o,
  input wire logic core_logic_power_o,
  input wire logic retained_power_o
);
  import pmg_pkg::*;
  // Any cause that must end Idle
  wire wake = (cpu_evt_i.irq_valid && cpu_evt_i.irq_prio > cpu_evt_i.cpu_prio) ||
    cpu_evt_i.wdt_timeout || cpu_evt_i.reset_req;
  // Halted but neither idle nor asleep means waiting on the regulator
  wire reg_wake = cpu_halt_o && !idle_o && !sleep_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one-cycle answer");
  AST_ENTER: assert property (cpu_evt_i.wait_exec && !cpu_halt_o |=> cpu_halt_o && (idle_o != sleep_o))
    else $error("wait did not halt into one low-power state");
  AST_IDLE_CAUSE: assert property ($rose(idle_o) |-> $past(cpu_evt_i.wait_exec) || $past(sleep_o))
    else $error("idle entered without wait");
  AST_IDLE_CLK: assert property (idle_o |-> cpu_halt_o && core_logic_power_o && !regulator_standby_o)
    else $error("idle changed more than the cpu clock");
  AST_STAY: assert property (idle_o && !wake |=> idle_o)
    else $error("idle left without a wake cause");
  AST_WAKE: assert property (idle_o && wake |=> !cpu_halt_o)
    else $error("idle not left on wake cause");
  AST_RUN_CLK: assert property (!cpu_halt_o |-> periph_clk_en_o == periph_access_en_o)
    else $error("peripheral clock wrong while running");
  AST_GATE: assert property ((periph_clk_en_o & ~periph_access_en_o) == '0)
    else $error("disabled peripheral has a clock");
  AST_STANDBY: assert property (regulator_standby_o |-> sleep_o)
    else $error("regulator standby outside sleep");
  AST_RET: assert property (retention_reg_en_o |-> sleep_o && !retention_config_bit_i)
    else $error("retention regulator on wrongly");
  AST_CORE: assert property (core_logic_power_o == !retention_reg_en_o && retained_power_o)
    else $error("core power domains wrong");
  AST_REG_HOLD: assert property (reg_wake && !vreg_ready_i |=> cpu_halt_o)
    else $error("execution resumed before regulator ready");
  AST_REG_DONE: assert property (reg_wake && vreg_ready_i |-> ##[0:3] !cpu_halt_o)
    else $error("regulator ready but cpu still halted");
endmodule

bind pmg_power_ctrl pmg_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cpu_evt_i(cpu_evt_i),
  .retention_config_bit_i(retention_config_bit_i), .vreg_ready_i(vreg_ready_i),
  .cpu_halt_o(cpu_halt_o), .idle_o(idle_o), .sleep_o(sleep_o),
  .periph_clk_en_o(periph_clk_en_o), .periph_access_en_o(periph_access_en_o),
  .regulator_standby_o(regulator_standby_o), .retention_reg_en_o(retention_reg_en_o),
  .core_logic_power_o(core_logic_power_o), .retained_power_o(retained_power_o));

// ---- sim/pmg_vreg_model.sv ----
`timescale 1ns/100ps
// ******
// Main regulator readiness model
// ******
module pmg_vreg_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  input wire logic slow_i,
  output logic ready_o
);
  logic [4:0] cnt;
  // Output collapses in standby; slow mode stretches recovery so a
  // premature restart of the cpu becomes visible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 5'h00;
      ready_o <= 1'b1;
    end else if (standby_i) begin
      cnt <= slow_i ? 5'h14 : 5'h02;
      ready_o <= 1'b0;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end else begin
      ready_o <= 1'b1;
    end
  end
endmodule

// ---- sim/pmg_power_ctrl_tb.sv ----
`timescale 1ns/100ps
`include "pmg_defines.svh"
module pmg_power_ctrl_tb;
  import pmg_pkg::*;
  localparam logic [31:0] RST_DIS [7] = '{`PMG_RST_DIS1, `PMG_RST_DIS2, `PMG_RST_DIS3,
    `PMG_RST_DIS4, `PMG_RST_DIS5, `PMG_RST_DIS6, `PMG_RST_DIS7};
  // Register and bit of each peripheral, in clock-enable order
  localparam int MAP_REG [18] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 4, 4, 4, 4, 5, 5, 6};
  localparam int MAP_BIT [18] = '{0, 12, 20, 0, 1, 24, 25, 8, 9, 10, 0, 0, 1, 8, 9, 0, 8, 3};
  logic clk_i;
  logic rst_i;
  pmg_wb_req_t wb;
  pmg_cpu_evt_t evt;
  logic [31:0] wb_dat, rd;
  logic wb_ack, halt, idle, sleep, stby, ret, core, kept, vready, slow, cfg;
  logic [`PMG_NUM_PERIPH-1:0] clk_en, acc_en;
  int n_errors, n_tests, cycles;

  pmg_power_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .cpu_evt_i(evt), .retention_config_bit_i(cfg),
    .vreg_ready_i(vready), .cpu_halt_o(halt), .idle_o(idle), .sleep_o(sleep),
    .periph_clk_en_o(clk_en), .periph_access_en_o(acc_en), .regulator_standby_o(stby),
    .retention_reg_en_o(ret), .core_logic_power_o(core), .retained_power_o(kept));
  pmg_vreg_model u_vreg (.clk_i(clk_i), .rst_i(rst_i), .standby_i(stby), .slow_i(slow),
    .ready_o(vready));

  // ******
  // Shared tasks
  // ******
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One classic cycle; request held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb <= '0;
  endtask
  task automatic unlock(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, `PMG_OFS_SYS_KEY, `PMG_KEY_FIRST);
    bus(1'b1, `PMG_OFS_SYS_KEY, `PMG_KEY_SECOND);
    bus(1'b1, adr, dat);
    bus(1'b1, `PMG_OFS_SYS_KEY, 32'h00000000);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic enter_wait;
    @(posedge clk_i);
    evt.wait_exec <= 1'b1;
    @(posedge clk_i);
    evt.wait_exec <= 1'b0;
    @(negedge clk_i);
  endtask

  // ******
  // Scenarios
  // ******
  task automatic t_reset_regs;
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, `PMG_OFS_DIS_BASE + 8'(16 * i), 32'h0);
      chk("disable reset", RST_DIS[i], rd);
    end
    bus(1'b0, `PMG_OFS_PWR_CTRL, 32'h0);
    chk("power reset", `PMG_RST_PWR_CTRL, rd);
    bus(1'b1, 8'h44, 32'hFFFFFFFF);
    bus(1'b0, 8'h44, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("clocks at reset", 32'h0003FFFF, {14'h0, clk_en});
  endtask
  task automatic t_bitmap;
    logic [7:0] adr;
    for (int i = 0; i < 18; i++) begin
      adr = `PMG_OFS_DIS_BASE + 8'(16 * MAP_REG[i]);
      bus(1'b1, adr, 32'h1 << MAP_BIT[i]);
      bus(1'b0, adr, 32'h0);
      chk("disable bit", RST_DIS[MAP_REG[i]] | (32'h1 << MAP_BIT[i]), rd);
      chk("gated clock", {14'h0, ~(18'h00001 << i)}, {14'h0, clk_en});
      chk("access", {14'h0, ~(18'h00001 << i)}, {14'h0, acc_en});
      bus(1'b1, adr, 32'h0);
    end
  endtask
  task automatic t_lock;
    unlock(`PMG_OFS_DIS_CTRL, 32'h00000800);
    bus(1'b1, `PMG_OFS_DIS_BASE, 32'h1);
    bus(1'b0, `PMG_OFS_DIS_BASE, 32'h0);
    chk("locked write", RST_DIS[0], rd);
    bus(1'b1, `PMG_OFS_DIS_CTRL, 32'h0);
    bus(1'b1, `PMG_OFS_SYS_KEY, `PMG_KEY_FIRST);
    bus(1'b1, 8'h44, 32'h0);
    bus(1'b1, `PMG_OFS_SYS_KEY, `PMG_KEY_SECOND);
    bus(1'b1, `PMG_OFS_DIS_CTRL, 32'h0);
    bus(1'b0, `PMG_OFS_DIS_CTRL, 32'h0);
    chk("lock kept", 32'h00000800, rd);
    unlock(`PMG_OFS_DIS_CTRL, 32'h0);
    bus(1'b0, `PMG_OFS_DIS_CTRL, 32'h0);
    chk("lock cleared", 32'h0, rd);
  endtask
  task automatic t_sleep;
    logic [1:0] v;
    int n;
    bus(1'b1, `PMG_OFS_OSC_CTRL, 32'h10);
    bus(1'b0, `PMG_OFS_OSC_CTRL, 32'h0);
    chk("sleep bit locked", 32'h0, rd);
    unlock(`PMG_OFS_OSC_CTRL, 32'h10);
    for (int m = 0; m < 4; m++) begin
      v = 2'(32'hB1 >> (2 * m)); // Normal, standby, retention, both
      slow <= (v == 2'b00);
      bus(1'b1, `PMG_OFS_PWR_CTRL, {30'h0, v});
      enter_wait;
      chk("sleep state", 32'h5, {29'h0, halt, idle, sleep});
      chk("standby", {31'h0, !v[0]}, {31'h0, stby});
      chk("retention", {30'h0, v[1], !v[1]}, {30'h0, ret, core});
      bus(1'b0, `PMG_OFS_STATUS, 32'h0);
      chk("mode", {30'h0, v[1], !v[0]}, {30'h0, rd[3:2]});
      evt.irq_valid <= 1'b1;
      evt.irq_prio <= 3'h5;
      n = 0;
      settle(1);
      while (halt === 1'b1 && n < 40) begin
        n++;
        settle(0);
        @(posedge clk_i);
        @(negedge clk_i);
      end
      chk("woken", 32'h0, {31'h0, halt});
      chk("standby wait", {31'h0, slow}, {31'h0, n > 10});
      @(posedge clk_i);
      evt.irq_valid <= 1'b0;
    end
    unlock(`PMG_OFS_OSC_CTRL, 32'h0);
  endtask
  task automatic t_idle;
    bus(1'b1, `PMG_OFS_STOP_IDLE, 32'h800);
    enter_wait;
    chk("idle state", 32'h6, {29'h0, halt, idle, sleep});
    chk("idle clocks", 32'h0003F7FF, {14'h0, clk_en});
    @(posedge clk_i);
    evt.irq_valid <= 1'b1;
    evt.irq_prio <= 3'h2;
    settle(4);
    chk("equal priority", 32'h1, {31'h0, idle});
    @(posedge clk_i);
    evt.irq_prio <= 3'h5;
    settle(1);
    chk("woken", 32'h0, {31'h0, halt});
    chk("clocks back", 32'h0003FFFF, {14'h0, clk_en});
    @(posedge clk_i);
    evt.irq_valid <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      enter_wait;
      @(posedge clk_i);
      if (k == 0) evt.wdt_timeout <= 1'b1;
      else evt.reset_req <= 1'b1;
      settle(1);
      chk("other wake", 32'h0, {31'h0, halt});
      @(posedge clk_i);
      evt.wdt_timeout <= 1'b0;
      evt.reset_req <= 1'b0;
    end
  endtask
  // Config bit at one keeps the retention regulator off; needs a fresh reset
  task automatic t_cfg;
    @(posedge clk_i);
    cfg <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    unlock(`PMG_OFS_OSC_CTRL, 32'h10);
    bus(1'b1, `PMG_OFS_PWR_CTRL, 32'h3);
    enter_wait;
    chk("cfg sleep", 32'h5, {29'h0, halt, idle, sleep});
    chk("cfg retention", 32'h1, {30'h0, ret, core});
    bus(1'b0, `PMG_OFS_STATUS, 32'h0);
    chk("cfg status", 32'h8, {28'h0, rd[5:2]});
    evt.irq_valid <= 1'b1;
    evt.irq_prio <= 3'h2;
    settle(1);
    chk("low irq idle", 32'h6, {29'h0, halt, idle, sleep});
    @(posedge clk_i);
    evt.irq_prio <= 3'h5;
    settle(1);
    chk("sleep woken", 32'h0, {31'h0, halt});
    @(posedge clk_i);
    evt.irq_valid <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("Counts: %0d checks, %0d errors", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Free-running clock at 125 MHz
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_i = 1'b1;
    wb = '0;
    evt = '0;
    evt.cpu_prio = 3'h2;
    slow = 1'b0;
    cfg = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_regs();
    t_bitmap();
    t_lock();
    t_sleep();
    t_idle();
    t_cfg();
    tally_and_finish();
  end
endmodule
